// *** rtl/auto_reload_timer_three.sv ***
/*
 * Auto-reload timer three: 16-bit or split 8-bit counters with reload,
 * overflow flags and a level interrupt request, on an SFR port.
 * Assumes single-cycle SFR reads and writes from the core on clk.
 */
`timescale 1ns/1ps
module auto_reload_timer_three
	import timer_three_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Clock control bits from the clock control register
	input  wire logic       high_byte_fast_clock_select,
	input  wire logic       low_byte_fast_clock_select,
	// External oscillator and interrupt
	input  wire logic       ext_clk,
	input  wire logic       timer_irq_enable,
	output logic            irq
);
	tick_bus_if ticks ();

	timer_tick_gen u_ticks (
		.clk     (clk),
		.rst_n   (rst_n),
		.ext_clk (ext_clk),
		.ticks   (ticks.source)
	);

	logic [7:0] control_q, control_d;
	logic [7:0] reload_low_q, reload_low_d;
	logic [7:0] reload_high_q, reload_high_d;
	logic [7:0] count_low_byte_q, count_low_byte_d;
	logic [7:0] count_high_byte_q, count_high_byte_d;
	logic [7:0] rdata_d;
	logic       split, run, ext_sel;
	logic       tick16, tick_low, tick_high;
	logic       inc_low, inc_high, wrap_low, wrap_high, wrap16;
	logic       wr_ctl;

	assign split   = control_q[BIT_SPLIT];
	assign run     = control_q[BIT_RUN];
	assign ext_sel = control_q[BIT_EXT_SEL];
	assign wr_ctl  = sfr_wr && (sfr_addr == ADDR_CONTROL);

	always_comb begin
		// 16-bit mode source follows the low-byte select
		if (low_byte_fast_clock_select) begin
			tick16 = ticks.sys_tick;
		end else if (ext_sel) begin
			tick16 = ticks.ext8_tick;
		end else begin
			tick16 = ticks.div12_tick;
		end
		tick_low  = low_byte_fast_clock_select ? ticks.sys_tick
			: (ext_sel ? ticks.ext8_tick : ticks.div12_tick);
		tick_high = high_byte_fast_clock_select ? ticks.sys_tick
			: (ext_sel ? ticks.ext8_tick : ticks.div12_tick);

		if (split) begin
			inc_low  = tick_low;
			inc_high = tick_high && run;
		end else begin
			inc_low  = tick16 && run;
			inc_high = tick16 && run && (count_low_byte_q == 8'hFF);
		end
		wrap_low  = inc_low && (count_low_byte_q == 8'hFF);
		wrap_high = inc_high && (count_high_byte_q == 8'hFF);
		wrap16    = !split && wrap_low && wrap_high;

		count_low_byte_d  = count_low_byte_q;
		count_high_byte_d = count_high_byte_q;
		if (wrap16) begin
			count_low_byte_d  = reload_low_q;
			count_high_byte_d = reload_high_q;
		end else begin
			if (inc_low) begin
				count_low_byte_d = wrap_low && split ? reload_low_q
					: count_low_byte_q + 8'h01;
			end
			if (inc_high) begin
				count_high_byte_d = wrap_high ? reload_high_q
					: count_high_byte_q + 8'h01;
			end
		end
		if (sfr_wr && (sfr_addr == ADDR_COUNT_LOW)) begin
			count_low_byte_d = sfr_wdata;
		end
		if (sfr_wr && (sfr_addr == ADDR_COUNT_HIGH)) begin
			count_high_byte_d = sfr_wdata;
		end

		reload_low_d  = (sfr_wr && sfr_addr == ADDR_RELOAD_LOW) ? sfr_wdata : reload_low_q;
		reload_high_d = (sfr_wr && sfr_addr == ADDR_RELOAD_HIGH) ? sfr_wdata : reload_high_q;

		control_d = control_q;
		if (wr_ctl) begin
			control_d = sfr_wdata & CONTROL_WMASK;
		end
		// Hardware set wins over a software clear in the same cycle
		if (wrap_high) begin
			control_d[BIT_HIGH_FLAG] = 1'b1;
		end
		if (wrap_low) begin
			control_d[BIT_LOW_FLAG] = 1'b1;
		end

		if (sfr_addr == ADDR_CONTROL) begin
			rdata_d = control_q;
		end else if (sfr_addr == ADDR_RELOAD_LOW) begin
			rdata_d = reload_low_q;
		end else if (sfr_addr == ADDR_RELOAD_HIGH) begin
			rdata_d = reload_high_q;
		end else if (sfr_addr == ADDR_COUNT_LOW) begin
			rdata_d = count_low_byte_q;
		end else if (sfr_addr == ADDR_COUNT_HIGH) begin
			rdata_d = count_high_byte_q;
		end else begin
			rdata_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_q         <= CONTROL_RESET;
			reload_low_q      <= BYTE_RESET;
			reload_high_q     <= BYTE_RESET;
			count_low_byte_q  <= BYTE_RESET;
			count_high_byte_q <= BYTE_RESET;
			sfr_rdata         <= BYTE_RESET;
			irq               <= 1'b0;
		end else begin
			control_q         <= control_d;
			reload_low_q      <= reload_low_d;
			reload_high_q     <= reload_high_d;
			count_low_byte_q  <= count_low_byte_d;
			count_high_byte_q <= count_high_byte_d;
			sfr_rdata         <= rdata_d;
			// Level request from sticky flags and enables
			irq <= timer_irq_enable && (control_d[BIT_HIGH_FLAG]
				|| (control_d[BIT_LOW_FLAG] && control_d[BIT_LOW_IRQ_EN]));
		end
	end
endmodule // auto_reload_timer_three

// *** rtl/timer_three_pkg.sv ***
/*
 * Constants for the auto-reload timer three: register offsets, control bit
 * positions, reset values and clock-source counts.
 * Assumes an 8-bit special function register port driven by the core.
 */
// Function
// - Counter is 16 bits made of separately addressable low and high byte registers.
// - Control bit 3 selects one 16-bit timer or two 8-bit timers.
// - 16-bit mode counts on system clock, system clock/12 or external clock/8.
// - External/8 tick is resynchronized; external clock must not exceed system clock.
// - 16-bit wrap loads reload value and sets high overflow flag bit 7.
// - 16-bit mode requests interrupt on each overflow when timer interrupt enabled.
// - 16-bit mode with bit 5 set also interrupts on low byte wrap.
// - Split mode reloads each byte counter from its own reload register.
// - In split mode run control gates only the high counter.
// - Each split byte uses its fast select, else external select picks /12 or /8.
// - Split mode sets high or low overflow flag when that byte wraps.
// - Split mode interrupts on high overflow, and low overflow if enabled.
// - Hardware never clears overflow flags; software clears them and checks both.
// - Run control starts and stops the whole timer in 16-bit mode.
package timer_three_pkg;

	localparam logic [7:0] ADDR_CONTROL     = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;

	localparam int BIT_HIGH_FLAG  = 7;
	localparam int BIT_LOW_FLAG   = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_SPLIT      = 3;
	localparam int BIT_RUN        = 2;
	localparam int BIT_EXT_SEL    = 0;

	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_WMASK  = 8'hED;
	localparam logic [7:0] BYTE_RESET     = 8'h00;

	localparam int SYS_DIVIDE = 12;
	localparam int EXT_DIVIDE = 8;

endpackage

// *** rtl/tick_bus_if.sv ***
/*
 * Interface carrying the three prescaled count ticks from the tick generator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface tick_bus_if;
	logic sys_tick;
	logic div12_tick;
	logic ext8_tick;
	modport source (output sys_tick, output div12_tick, output ext8_tick);
	modport sink   (input sys_tick, input div12_tick, input ext8_tick);
endinterface

// *** rtl/timer_tick_gen.sv ***
/*
 * Tick generator: system clock, system clock divided by 12, and the external
 * oscillator divided by 8 resynchronized to the system clock.
 * Assumes ext_clk is a free level no faster than clk.
 */
`timescale 1ns/1ps
module timer_tick_gen
	import timer_three_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// External oscillator level
	input  wire logic ext_clk,
	// Ticks
	tick_bus_if.source ticks
);
	logic [3:0] div12_q, div12_d;
	logic [2:0] sync_q, sync_d;
	logic [2:0] ext_cnt_q, ext_cnt_d;
	logic       ext_pulse;

	always_comb begin
		div12_d   = (div12_q == 4'(SYS_DIVIDE - 1)) ? 4'h0 : div12_q + 4'h1;
		sync_d    = {sync_q[1:0], ext_clk};
		ext_pulse = sync_q[1] & ~sync_q[2];
		ext_cnt_d = ext_pulse ? ext_cnt_q + 3'h1 : ext_cnt_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div12_q   <= 4'h0;
			sync_q    <= 3'h0;
			ext_cnt_q <= 3'h0;
		end else begin
			div12_q   <= div12_d;
			sync_q    <= sync_d;
			ext_cnt_q <= ext_cnt_d;
		end
	end

	assign ticks.sys_tick   = 1'b1;
	assign ticks.div12_tick = (div12_q == 4'(SYS_DIVIDE - 1));
	assign ticks.ext8_tick  = ext_pulse && (ext_cnt_q == 3'(EXT_DIVIDE - 1));
endmodule // timer_tick_gen

// *** bench/auto_reload_timer_three_properties.sv ***
/* Port checker for timer three: read-back, flags, irq level.
   Assumes the one-cycle registered read of the SFR port. */
`timescale 1ns/1ps
module auto_reload_timer_three_properties
	import timer_three_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       timer_irq_enable,
	input wire logic       irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_unmapped_zero: assert property (
		(sfr_addr < 8'h91 || sfr_addr > 8'h95) |=> sfr_rdata == 8'h00) else $error("unmapped read");
	chk_unused_bits: assert property (
		sfr_addr == 8'h91 |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0) else $error("unused bit");
	chk_irq_disabled: assert property (
		!timer_irq_enable ##1 !timer_irq_enable |-> !irq) else $error("irq while disabled");
	chk_irq_held: assert property (
		irq && timer_irq_enable && !sfr_wr |=> irq) else $error("irq dropped");
	chk_flag_sticky: assert property (
		sfr_rdata[7] && $past(sfr_addr) == 8'h91 && sfr_addr == 8'h91 && !sfr_wr && !$past(sfr_wr)
		|=> sfr_rdata[7]) else $error("flag cleared by hardware");
	chk_reload_low: assert property (
		sfr_wr && sfr_addr == 8'h92 ##1 sfr_addr == 8'h92 && !sfr_wr
		|=> sfr_rdata == $past(sfr_wdata, 2)) else $error("reload low readback");
	chk_reload_high: assert property (
		sfr_wr && sfr_addr == 8'h93 ##1 sfr_addr == 8'h93 && !sfr_wr
		|=> sfr_rdata == $past(sfr_wdata, 2)) else $error("reload high readback");
	chk_ctrl_readback: assert property (
		sfr_wr && sfr_addr == 8'h91 ##1 sfr_addr == 8'h91 && !sfr_wr
		|=> (sfr_rdata & 8'h2D) == ($past(sfr_wdata, 2) & 8'h2D)) else $error("control readback");
	cover property ($rose(irq));
	cover property (sfr_addr == 8'h91 ##1 sfr_rdata[7]);
	cover property (sfr_addr == 8'h91 ##1 sfr_rdata[6]);
endmodule // auto_reload_timer_three_properties
bind auto_reload_timer_three auto_reload_timer_three_properties props_inst (.clk(clk),
	.rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable), .irq(irq));

// *** bench/auto_reload_timer_three_bench.sv ***
/* Self-checking bench for timer three: reads queued as notes, checked by a monitor.
   Assumes the checker is bound in; ext_clk runs slower than clk. */
`timescale 1ns/1ps
module auto_reload_timer_three_bench;
	import timer_three_pkg::*;
	logic        clk, rst_n, sfr_wr, hi_fast, lo_fast, ext_clk, irq_en, irq, chk_now;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, r;
	logic [17:0] notes[$];
	int          errors, n_compared, seed;
	auto_reload_timer_three auto_reload_timer_three_inst (.clk(clk), .rst_n(rst_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.high_byte_fast_clock_select(hi_fast), .low_byte_fast_clock_select(lo_fast),
		.ext_clk(ext_clk), .timer_irq_enable(irq_en), .irq(irq));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		ext_clk = 0;
		forever #37 ext_clk = ~ext_clk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clk);
		sfr_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e, input logic [8:0] m);
		@(negedge clk);
		sfr_addr = a;
		notes.push_back({e, m});
		chk_now <= 1'b1;
		@(negedge clk);
		chk_now <= 1'b0;
	endtask
	task automatic cmp(input logic [17:0] n, input logic [8:0] got);
		n_compared++;
		if ((got & n[8:0]) !== n[17:9]) begin
			errors++;
			$display("ERROR irq_rdata expected %h seen %h", n[17:9], got & n[8:0]);
		end
	endtask
	// Read data and irq settle one edge after the address, so look half a cycle later
	always @(negedge clk) begin
		if (chk_now === 1'b1) begin
			cmp(notes.pop_front(), {irq, sfr_rdata});
		end
	end
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100us;
		errors++;
		tally_and_finish();
	end
	initial begin
		seed = 32'h2107;
		{errors, n_compared, chk_now, sfr_wr, sfr_addr, sfr_wdata, hi_fast} = '0;
		{rst_n, lo_fast, irq_en} = 3'b001;
		repeat (5) @(negedge clk);
		rst_n = 1;
		rd(8'h91, 9'h000, 9'h1FF);
		rd(8'h90, 9'h000, 9'h0FF);
		wr(8'h91, 8'h12);
		rd(8'h91, 9'h000, 9'h0FF);
		repeat (4) begin
			r = 8'($random(seed));
			wr(8'h92, r);
			rd(8'h92, {1'b0, r}, 9'h0FF);
		end
		wr(8'h92, 8'hFE);
		wr(8'h93, 8'hFF);
		wr(8'h94, 8'h10);
		repeat (10) @(negedge clk);
		rd(8'h94, 9'h010, 9'h0FF);
		wr(8'h94, 8'hFE);
		wr(8'h95, 8'hFF);
		irq_en = 0;
		wr(8'h91, 8'h05);
		repeat (300) @(negedge clk);
		rd(8'h91, 9'h085, 9'h1BF);
		irq_en = 1;
		rd(8'h91, 9'h185, 9'h1BF);
		// Stop first so no wrap can race the clearing write
		wr(8'h91, 8'hC0);
		wr(8'h91, 8'h00);
		rd(8'h91, 9'h000, 9'h1FF);
		wr(8'h92, 8'hF0);
		wr(8'h94, 8'hF0);
		wr(8'h95, 8'h33);
		lo_fast = 1;
		wr(8'h91, 8'h28);
		repeat (20) @(negedge clk);
		rd(8'h95, 9'h033, 9'h0FF);
		rd(8'h91, 9'h168, 9'h1FF);
		lo_fast = 0;
		wr(8'h95, 8'hFF);
		wr(8'h91, 8'h2C);
		repeat (30) @(negedge clk);
		rd(8'h91, 9'h1AC, 9'h1BF);
		// High byte on the fast clock wraps from 0xF8 well inside 20 cycles
		wr(8'h91, 8'h08);
		wr(8'h95, 8'hF8);
		hi_fast = 1;
		wr(8'h91, 8'h0C);
		repeat (20) @(negedge clk);
		rd(8'h91, 9'h18C, 9'h18C);
		// Reset in mid-run clears flags and the request
		rst_n = 0;
		@(negedge clk);
		rst_n = 1;
		rd(8'h91, 9'h000, 9'h1FF);
		tally_and_finish();
	end
endmodule // auto_reload_timer_three_bench
